/* portb_pkg.sv */
// shared constants, codes and the long-word swap for the port-b steering
// assumes one clock, the port-b clock, drives every flip-flop
package portb_pkg;

	localparam int LONG_W = 36;
	localparam int LANE_W = 9;
	localparam int LANES = 4;

	// size select codes {size_sel_hi, size_sel_lo}
	localparam logic [1:0] SIZE_LONG = 2'h0;
	localparam logic [1:0] SIZE_BYTE = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;
	localparam logic [1:0] SIZE_MAIL = 2'h3;

	// last piece index per size
	localparam logic [1:0] LAST_LONG = 2'h0;
	localparam logic [1:0] LAST_WORD = 2'h1;
	localparam logic [1:0] LAST_BYTE = 2'h3;

	// swap codes {swap_sel_hi, swap_sel_lo}
	localparam logic [1:0] SWAP_NONE = 2'h0;
	localparam logic [1:0] SWAP_FULL = 2'h1;
	localparam logic [1:0] SWAP_HALF = 2'h2;
	localparam logic [1:0] SWAP_BYTE = 2'h3;

	// register byte offsets
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_MASK = 8'h04;
	localparam logic [7:0] ADDR_CTRL = 8'h08;
	localparam logic [7:0] ADDR_STATE = 8'h0c;

	// status / mask bit positions
	localparam int EV_COMMIT = 0;
	localparam int EV_MAIL = 1;
	localparam int EV_PARITY = 2;
	localparam int EV_LOST = 3;
	localparam int EV_N = 4;

	// control bits and reset values
	localparam int CTRL_EN = 0;
	localparam int CTRL_ODD = 1;
	localparam logic [1:0] CTRL_RST = 2'h1;
	localparam logic [EV_N-1:0] MASK_RST = 4'h0;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	function automatic logic [35:0] swap_long(input logic [35:0] d,
		input logic [1:0] m);
		unique case (m)
			SWAP_NONE: swap_long = d;
			SWAP_FULL: swap_long = {d[8:0], d[17:9], d[26:18], d[35:27]};
			SWAP_HALF: swap_long = {d[17:0], d[35:18]};
			SWAP_BYTE: swap_long = {d[26:18], d[35:27], d[8:0], d[17:9]};
		endcase
	endfunction

endpackage

/* portb_regs_if.sv */
// carrier between the steering core and its register slave
// assumes both ends share i_clk
`timescale 1ns/1ns
interface portb_regs_if;
	logic port_en;
	logic parity_odd;
	logic [3:0] events;
	logic [15:0] state;
	modport regs (output port_en, parity_odd, input events, state);
	modport core (input port_en, parity_odd, output events, state);
endinterface

/* portb_lane_parity.sv */
// per-lane parity checker for the four port-b byte lanes
// assumes the parity bit is the top bit of each lane
`timescale 1ns/1ns
module portb_lane_parity
	import portb_pkg::*;
#(
	parameter int LANE_BITS = LANE_W,
	parameter int N_LANES = LANES
) (
	// data in
	input wire logic [LANE_BITS*N_LANES-1:0] i_data,
	input wire logic i_odd,
	// per-lane error
	output logic [N_LANES-1:0] o_err
);
	generate
		if (LANE_BITS < 2 || N_LANES < 1) begin : g_bad
			$error("lane width or count unusable");
		end
		for (genvar l = 0; l < N_LANES; l++) begin : g_lane
			assign o_err[l] = i_odd ? ~^i_data[l*LANE_BITS +: LANE_BITS]
				: ^i_data[l*LANE_BITS +: LANE_BITS];
		end
	endgenerate
endmodule

/* portb_axil_regs.sv */
// axi4-lite slave: status (write one to clear), mask, control, state
// assumes single outstanding write and read from the master
`timescale 1ns/1ns
module portb_axil_regs
	import portb_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// write address and data
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [7:0] i_awaddr,
	input wire logic i_wvalid,
	output logic o_wready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	// write response
	output logic o_bvalid,
	input wire logic i_bready,
	output logic [1:0] o_bresp,
	// read
	input wire logic i_arvalid,
	output logic o_arready,
	input wire logic [7:0] i_araddr,
	output logic o_rvalid,
	input wire logic i_rready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	// core side
	portb_regs_if.regs core,
	output logic o_irq
);
	logic aw_have, w_have;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic [EV_N-1:0] status, mask;
	logic [1:0] ctrl;
	logic do_wr, clr_ok;

	assign o_awready = !aw_have && !o_bvalid;
	assign o_wready = !w_have && !o_bvalid;
	assign o_arready = !o_rvalid;
	assign do_wr = aw_have && w_have && !o_bvalid;
	assign clr_ok = do_wr && aw_addr == ADDR_STATUS && w_strb[0];
	assign core.port_en = ctrl[CTRL_EN];
	assign core.parity_odd = ctrl[CTRL_ODD];
	assign o_irq = |(status & mask);

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			aw_have <= 1'b0;
			w_have <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else begin
			if (i_awvalid && o_awready) begin
				aw_have <= 1'b1;
				aw_addr <= i_awaddr;
			end else if (do_wr) begin
				aw_have <= 1'b0;
			end
			if (i_wvalid && o_wready) begin
				w_have <= 1'b1;
				w_data <= i_wdata;
				w_strb <= i_wstrb;
			end else if (do_wr) begin
				w_have <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_bvalid <= 1'b0;
			o_bresp <= RESP_OKAY;
			mask <= MASK_RST;
			ctrl <= CTRL_RST;
		end else begin
			if (do_wr) begin
				o_bvalid <= 1'b1;
				o_bresp <= RESP_OKAY;
				unique case (aw_addr)
					ADDR_STATUS: ;
					ADDR_MASK: if (w_strb[0]) mask <= w_data[EV_N-1:0];
					ADDR_CTRL: if (w_strb[0]) ctrl <= w_data[1:0];
					ADDR_STATE: ;
					default: o_bresp <= RESP_SLVERR;
				endcase
			end else if (i_bready) begin
				o_bvalid <= 1'b0;
			end
		end
	end

	// set wins over the clear
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			status <= '0;
		end else begin
			status <= (status & ~(clr_ok ? w_data[EV_N-1:0] : '0))
				| core.events;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_rvalid <= 1'b0;
			o_rdata <= 32'h0000_0000;
			o_rresp <= RESP_OKAY;
		end else if (i_arvalid && o_arready) begin
			o_rvalid <= 1'b1;
			o_rresp <= RESP_OKAY;
			unique case (i_araddr)
				ADDR_STATUS: o_rdata <= {28'h000_0000, status};
				ADDR_MASK: o_rdata <= {28'h000_0000, mask};
				ADDR_CTRL: o_rdata <= {30'h0000_0000, ctrl};
				ADDR_STATE: o_rdata <= {16'h0000, core.state};
				default: begin
					o_rdata <= 32'h0000_0000;
					o_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (i_rready) begin
			o_rvalid <= 1'b0;
		end
	end
endmodule

/* portb_bus_match.sv */
// port-b bus matching, byte swapping, mailbox select and parity flag
// What this block does
// R1 - long writes stored with chosen byte swap
// R2 - long reads driven with chosen byte swap
// R3 - big-endian word writes: upper lines, first high
// R4 - little-endian word writes: lower lines, first low
// R5 - big-endian bytes: top lane, most first
// R6 - little-endian bytes: bottom lane, least first
// R7 - big-endian word reads: upper half first
// R8 - little-endian word reads: lower half first
// R9 - both size selects high writes mailbox
// R10 - both size selects high reads mailbox
// R11 - word parity flag covers active lanes
// R12 - word reads hold unused half
// R13 - byte reads hold unused lanes
// R14 - swap mode fixed on first piece
// R15 - new size restarts assembly, loses pieces
// R16 - mailbox data never swapped
// R17 - last piece commits the long word
// R18 - selects sampled on every clock edge
// assumes queue head data is valid while a queue read is made
//
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
module portb_bus_match
	import portb_pkg::*;
#(
	parameter int DATA_W = LONG_W
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// port-b pins
	input wire logic i_portb_cs,
	input wire logic i_portb_write,
	input wire logic i_size_sel_lo,
	input wire logic i_size_sel_hi,
	input wire logic i_endian_sel,
	input wire logic i_swap_sel_lo,
	input wire logic i_swap_sel_hi,
	input wire logic [DATA_W-1:0] i_portb_data,
	output logic [DATA_W-1:0] o_portb_data,
	output logic o_portb_data_oe,
	output logic o_portb_parity_err_n,
	// queues and mailboxes
	output logic o_b2a_wr_en,
	output logic [DATA_W-1:0] o_b2a_wr_data,
	output logic o_b2a_mail_wr,
	output logic [DATA_W-1:0] o_b2a_mail_data,
	input wire logic [DATA_W-1:0] i_a2b_data,
	output logic o_a2b_pop,
	input wire logic [DATA_W-1:0] i_a2b_mail_data,
	// axi4-lite
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [7:0] i_awaddr,
	input wire logic i_wvalid,
	output logic o_wready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	output logic o_bvalid,
	input wire logic i_bready,
	output logic [1:0] o_bresp,
	input wire logic i_arvalid,
	output logic o_arready,
	input wire logic [7:0] i_araddr,
	output logic o_rvalid,
	input wire logic i_rready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	// interrupt
	output logic o_irq
);
	generate
		if (DATA_W != LONG_W) begin : g_bad
			$error("port width must be 36");
		end
	endgenerate

	portb_regs_if regs_bus ();

	////////////////////////////////////////////////////////////////////
	// decode of the sampled selects
	logic [1:0] size, swap, last_w, last_r, cnt_w, cnt_r, wsize_q, rsize_q;
	logic [1:0] cnt_ew, cnt_er, swap_w, swap_ew, wr_lane, rd_lane;
	logic big, wr_acc, rd_acc, q_wr, q_rd, m_wr, m_rd, commit;
	logic [35:0] asm, merged, rd_word, cur;
	logic [3:0] lane_err, lane_mask;
	logic parity_bad, lost;

	function automatic logic [1:0] last_of(input logic [1:0] s);
		unique case (s)
			SIZE_WORD: last_of = LAST_WORD;
			SIZE_BYTE: last_of = LAST_BYTE;
			default: last_of = LAST_LONG;
		endcase
	endfunction

	assign size = {i_size_sel_hi, i_size_sel_lo}; // [R18]
	assign swap = {i_swap_sel_hi, i_swap_sel_lo};
	assign big = i_endian_sel;
	assign wr_acc = i_portb_cs && i_portb_write && regs_bus.port_en;
	assign rd_acc = i_portb_cs && !i_portb_write && regs_bus.port_en;
	assign m_wr = wr_acc && size == SIZE_MAIL; // [R9]
	assign m_rd = rd_acc && size == SIZE_MAIL; // [R10]
	assign q_wr = wr_acc && size != SIZE_MAIL;
	assign q_rd = rd_acc && size != SIZE_MAIL;
	assign last_w = last_of(size);
	assign last_r = last_w;
	assign cnt_ew = (size != wsize_q) ? 2'h0 : cnt_w; // [R15]
	assign cnt_er = (size != rsize_q) ? 2'h0 : cnt_r;
	assign swap_ew = (cnt_ew == 2'h0) ? swap : swap_w; // [R14]
	assign commit = q_wr && cnt_ew == last_w; // [R17]
	assign lost = q_wr && size != wsize_q && cnt_w != 2'h0; // [R15]
	assign o_portb_data_oe = rd_acc;

	////////////////////////////////////////////////////////////////////
	// write assembly
	always_comb begin
		merged = asm;
		wr_lane = big ? 2'(LAST_BYTE - cnt_ew) : cnt_ew;
		unique case (size)
			SIZE_WORD: begin
				if (big) begin // [R3]
					if (cnt_ew == 2'h0) merged[35:18] = i_portb_data[35:18];
					else merged[17:0] = i_portb_data[35:18];
				end else begin // [R4]
					if (cnt_ew == 2'h0) merged[17:0] = i_portb_data[17:0];
					else merged[35:18] = i_portb_data[17:0];
				end
			end
			SIZE_BYTE: begin
				if (big) // [R5]
					merged[wr_lane*LANE_W +: LANE_W] = i_portb_data[35:27];
				else // [R6]
					merged[wr_lane*LANE_W +: LANE_W] = i_portb_data[8:0];
			end
			default: merged = i_portb_data;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			asm <= 36'h0_0000_0000;
			cnt_w <= 2'h0;
			swap_w <= SWAP_NONE;
			wsize_q <= SIZE_LONG;
			o_b2a_wr_en <= 1'b0;
			o_b2a_wr_data <= 36'h0_0000_0000;
		end else begin
			o_b2a_wr_en <= commit;
			if (q_wr) begin
				wsize_q <= size;
				if (commit) begin
					o_b2a_wr_data <= swap_long(merged, swap_ew); // [R1] [R17]
					cnt_w <= 2'h0;
				end else begin
					asm <= merged;
					cnt_w <= 2'(cnt_ew + 2'h1);
					swap_w <= swap_ew; // [R14]
				end
			end
		end
	end

	// mailbox write bypasses assembly and swap
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_b2a_mail_wr <= 1'b0;
			o_b2a_mail_data <= 36'h0_0000_0000;
		end else begin
			o_b2a_mail_wr <= m_wr; // [R9]
			if (m_wr) o_b2a_mail_data <= i_portb_data; // [R16]
		end
	end

	////////////////////////////////////////////////////////////////////
	// read splitting
	assign cur = (cnt_er == 2'h0) ? swap_long(i_a2b_data, swap) : rd_word;
	assign rd_lane = big ? 2'(LAST_BYTE - cnt_er) : cnt_er;

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt_r <= 2'h0;
			rsize_q <= SIZE_LONG;
			rd_word <= 36'h0_0000_0000;
			o_a2b_pop <= 1'b0;
		end else begin
			o_a2b_pop <= q_rd && cnt_er == 2'h0;
			if (q_rd) begin
				rsize_q <= size;
				rd_word <= cur; // [R2]
				cnt_r <= (cnt_er == last_r) ? 2'h0 : 2'(cnt_er + 2'h1);
			end
		end
	end

	// only the active lanes load, the rest hold
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_portb_data <= 36'h0_0000_0000;
		end else if (m_rd) begin
			o_portb_data <= i_a2b_mail_data; // [R10] [R16]
		end else if (q_rd) begin
			unique case (size)
				SIZE_WORD: begin // [R12]
					if (big) // [R7]
						o_portb_data[35:18] <= (cnt_er == 2'h0) ?
							cur[35:18] : cur[17:0];
					else // [R8]
						o_portb_data[17:0] <= (cnt_er == 2'h0) ?
							cur[17:0] : cur[35:18];
				end
				SIZE_BYTE: begin // [R13]
					if (big)
						o_portb_data[35:27] <= cur[rd_lane*LANE_W +: LANE_W];
					else
						o_portb_data[8:0] <= cur[rd_lane*LANE_W +: LANE_W];
				end
				default: o_portb_data <= cur; // [R2]
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// parity flag on active write lanes
	portb_lane_parity u_parity (
		.i_data(i_portb_data),
		.i_odd(regs_bus.parity_odd),
		.o_err(lane_err)
	);

	always_comb begin
		unique case (size)
			SIZE_WORD: lane_mask = big ? 4'hc : 4'h3; // [R11]
			SIZE_BYTE: lane_mask = big ? 4'h8 : 4'h1;
			default: lane_mask = 4'hf;
		endcase
	end

	assign parity_bad = wr_acc && |(lane_err & lane_mask);

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) o_portb_parity_err_n <= 1'b1;
		else o_portb_parity_err_n <= !parity_bad; // [R11]
	end

	////////////////////////////////////////////////////////////////////
	// registers and interrupt
	assign regs_bus.events = {lost, parity_bad, m_wr, commit};
	assign regs_bus.state = {4'h0, wsize_q, rsize_q, cnt_w, cnt_r, swap_w,
		rd_word[35:34]};

	portb_axil_regs u_regs (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_awvalid(i_awvalid),
		.o_awready(o_awready),
		.i_awaddr(i_awaddr),
		.i_wvalid(i_wvalid),
		.o_wready(o_wready),
		.i_wdata(i_wdata),
		.i_wstrb(i_wstrb),
		.o_bvalid(o_bvalid),
		.i_bready(i_bready),
		.o_bresp(o_bresp),
		.i_arvalid(i_arvalid),
		.o_arready(o_arready),
		.i_araddr(i_araddr),
		.o_rvalid(o_rvalid),
		.i_rready(i_rready),
		.o_rdata(o_rdata),
		.o_rresp(o_rresp),
		.core(regs_bus.regs),
		.o_irq(o_irq)
	);

	////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);

	sequence word_big_first;
		q_wr && size == SIZE_WORD && big && cnt_ew == 2'h0;
	endsequence
	sequence word_big_second;
		q_wr && size == SIZE_WORD && big;
	endsequence

	long_write_a: assert property (q_wr && size == SIZE_LONG |=> // [R1]
		o_b2a_wr_en && o_b2a_wr_data ==
		swap_long($past(i_portb_data), $past(swap)))
		else $error("long write stored wrong");
	mail_write_a: assert property (m_wr |=> o_b2a_mail_wr && // [R9]
		!o_b2a_wr_en)
		else $error("mailbox write went astray");
	mail_noswap_a: assert property (m_wr |=> // [R16]
		o_b2a_mail_data == $past(i_portb_data))
		else $error("mailbox data altered");
	mail_read_a: assert property (m_rd |=> // [R10]
		o_portb_data == $past(i_a2b_mail_data))
		else $error("mailbox not driven on read");
	word_pair_a: assert property (word_big_first ##1 word_big_second // [R3]
		|=> o_b2a_wr_en && o_b2a_wr_data == swap_long({$past(
		i_portb_data[35:18], 2), $past(i_portb_data[35:18])},
		$past(swap, 2)))
		else $error("big word pair assembled wrong");
	word_hold_a: assert property (q_rd && size == SIZE_WORD && big // [R12]
		|=> o_portb_data[17:0] == $past(o_portb_data[17:0]))
		else $error("unused half changed");
	byte_hold_a: assert property (q_rd && size == SIZE_BYTE && !big // [R13]
		|=> o_portb_data[35:9] == $past(o_portb_data[35:9]))
		else $error("unused lanes changed");
	parity_word_a: assert property (wr_acc && size == SIZE_WORD && // [R11]
		!big && lane_err[3:2] != 2'h0 && lane_err[1:0] == 2'h0
		|=> o_portb_parity_err_n)
		else $error("parity flag saw an idle lane");
	swap_keep_a: assert property (q_wr && cnt_ew != 2'h0 && !commit // [R14]
		|=> swap_w == $past(swap_w))
		else $error("swap mode changed mid word");
	size_reset_a: assert property (lost |=> cnt_w <= 2'h1) // [R15]
		else $error("assembly not restarted");
endmodule

/* portb_master_model.sv */
// port-b bus master model: one piece per port-b clock
// assumes the block samples its port-b pins on the rising edge
`timescale 1ns/1ns
module portb_master_model (
	// clock
	input wire logic i_clk,
	// port-b pins
	output logic o_cs,
	output logic o_write,
	output logic o_size_sel_lo,
	output logic o_size_sel_hi,
	output logic o_endian_sel,
	output logic o_swap_sel_lo,
	output logic o_swap_sel_hi,
	output logic [35:0] o_data
);
	initial begin
		o_cs = 1'b0;
		o_write = 1'b0;
		{o_size_sel_hi, o_size_sel_lo} = 2'h0;
		o_endian_sel = 1'b0;
		{o_swap_sel_hi, o_swap_sel_lo} = 2'h0;
		o_data = 36'h0_0000_0000;
	end

	////////////////////////////////////////////////////////////////////////
	// one piece, sampled at the following edge
	task automatic put(input logic wr, input logic [1:0] sz,
		input logic big, input logic [1:0] sw, input logic [35:0] d);
		@(posedge i_clk);
		o_cs <= 1'b1;
		o_write <= wr;
		{o_size_sel_hi, o_size_sel_lo} <= sz;
		o_endian_sel <= big;
		{o_swap_sel_hi, o_swap_sel_lo} <= sw;
		o_data <= d;
	endtask

	// released bus shows the inverse of its last value
	task automatic idle();
		@(posedge i_clk);
		o_cs <= 1'b0;
		o_data <= ~o_data;
	endtask
endmodule

/* tb_portb_bus_match.sv */
// self-checking bench for the port-b steering block
// assumes the block's registered outputs update at the sampling edge
`timescale 1ns/1ns
module tb_portb_bus_match;
	import portb_pkg::*;

	localparam logic [35:0] L = 36'h1_2345_6789;
	localparam logic [35:0] A = 36'h9_8765_4321;
	localparam logic [35:0] M = 36'h5_a5a5_a5a5;
	localparam logic [35:0] ALL = 36'hf_ffff_ffff;

	logic i_clk, i_rst_b, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
	logic [7:0] i_awaddr, i_araddr;
	logic [31:0] i_wdata, o_rdata;
	logic [3:0] i_wstrb;
	logic [35:0] i_a2b_data, i_a2b_mail_data, i_portb_data, o_portb_data;
	logic [35:0] o_b2a_wr_data, o_b2a_mail_data;
	logic i_portb_cs, i_portb_write, i_size_sel_lo, i_size_sel_hi;
	logic i_endian_sel, i_swap_sel_lo, i_swap_sel_hi;
	logic o_portb_data_oe, o_portb_parity_err_n, o_b2a_wr_en, o_b2a_mail_wr;
	logic o_a2b_pop, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
	logic o_irq;
	logic [1:0] o_bresp, o_rresp;
	int bad_count, checks;

	portb_master_model portb_master_model_inst (.i_clk,
		.o_cs(i_portb_cs), .o_write(i_portb_write),
		.o_size_sel_lo(i_size_sel_lo), .o_size_sel_hi(i_size_sel_hi),
		.o_endian_sel(i_endian_sel), .o_swap_sel_lo(i_swap_sel_lo),
		.o_swap_sel_hi(i_swap_sel_hi), .o_data(i_portb_data));

	portb_bus_match portb_bus_match_inst (.i_clk, .i_rst_b, .i_portb_cs,
		.i_portb_write, .i_size_sel_lo, .i_size_sel_hi, .i_endian_sel,
		.i_swap_sel_lo, .i_swap_sel_hi, .i_portb_data, .o_portb_data,
		.o_portb_data_oe, .o_portb_parity_err_n, .o_b2a_wr_en,
		.o_b2a_wr_data, .o_b2a_mail_wr, .o_b2a_mail_data, .i_a2b_data,
		.o_a2b_pop, .i_a2b_mail_data, .i_awvalid, .o_awready, .i_awaddr,
		.i_wvalid, .o_wready, .i_wdata, .i_wstrb, .o_bvalid, .i_bready,
		.o_bresp, .i_arvalid, .o_arready, .i_araddr, .o_rvalid, .i_rready,
		.o_rdata, .o_rresp, .o_irq);

	initial begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end

	////////////////////////////////////////////////////////////////////////
	// helpers
	function automatic logic [35:0] sw(input logic [35:0] d,
		input logic [1:0] m);
		logic [8:0] a, b, c, e;
		{a, b, c, e} = d;
		case (m)
			2'h0: sw = d;
			2'h1: sw = {e, c, b, a};
			2'h2: sw = {c, e, a, b};
			default: sw = {b, a, e, c};
		endcase
	endfunction

	function automatic logic [35:0] sh(input logic [35:0] d, input int b,
		input int n);
		sh = b ? d << n : d >> n;
	endfunction

	task automatic chk(input logic [35:0] s, input logic [35:0] e);
		checks++;
		if (s !== e) begin
			bad_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task automatic print_verdict();
		if (bad_count == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic go(input logic wr, input logic [1:0] sz, input logic big,
		input logic [1:0] m, input logic [35:0] d);
		portb_master_model_inst.put(wr, sz, big, m, d);
		#1;
	endtask

	task automatic fin();
		portb_master_model_inst.idle();
		#1;
	endtask

	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		logic got, aw, wv;
		logic [1:0] br;
		got = 1'b0;
		br = 2'h3;
		@(posedge i_clk);
		i_awvalid <= 1'b1;
		i_awaddr <= a;
		i_wvalid <= 1'b1;
		i_wdata <= d;
		i_bready <= 1'b1;
		// waits for the answer; only the watchdog ends a hang
		while (!got) begin
			#1;
			aw = i_awvalid && o_awready;
			wv = i_wvalid && o_wready;
			got = i_bready && o_bvalid;
			br = o_bresp;
			@(posedge i_clk);
			if (aw) i_awvalid <= 1'b0;
			if (wv) i_wvalid <= 1'b0;
			if (got) i_bready <= 1'b0;
		end
		chk(36'(br), 36'(RESP_OKAY));
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic got, ar;
		got = 1'b0;
		@(posedge i_clk);
		i_arvalid <= 1'b1;
		i_araddr <= a;
		i_rready <= 1'b1;
		while (!got) begin
			#1;
			ar = i_arvalid && o_arready;
			got = i_rready && o_rvalid;
			d = o_rdata;
			r = o_rresp;
			@(posedge i_clk);
			if (ar) i_arvalid <= 1'b0;
			if (got) i_rready <= 1'b0;
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// watchdog
	initial begin
		repeat (3000) @(posedge i_clk);
		bad_count++;
		print_verdict();
	end

	////////////////////////////////////////////////////////////////////////
	// tests
	initial begin
		logic [35:0] ho, mk;
		logic [31:0] rd;
		logic [1:0] rr;
		int n, w;
		{i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h00;
		{i_awaddr, i_araddr, i_wdata} = 48'h0000_0000_0000;
		i_wstrb = 4'hf;
		i_a2b_data = A;
		i_a2b_mail_data = M;
		i_rst_b = 1'b0;
		repeat (3) @(posedge i_clk);
		i_rst_b <= 1'b1;
		axr(ADDR_CTRL, rd, rr);
		chk(36'(rd), 36'(CTRL_RST));
		axr(ADDR_MASK, rd, rr);
		chk(36'(rd), 36'(MASK_RST));
		axr(8'h10, rd, rr);
		chk(36'({rr, rd}), 36'({RESP_SLVERR, 32'h0000_0000}));
		// long words, write then read back to back
		for (int m = 0; m < 4; m++) begin
			go(1'b1, SIZE_LONG, 1'b0, 2'(m), L);
			go(1'b0, SIZE_LONG, 1'b0, 2'(m), L);
			chk(36'(o_portb_data_oe), 36'h1);
			chk(36'(o_b2a_wr_en), 36'h1);
			chk(o_b2a_wr_data, sw(L, 2'(m)));
			fin();
			chk(o_portb_data, sw(A, 2'(m)));
			chk(36'(o_a2b_pop), 36'h1);
		end
		// mailbox both ways, swap selects ignored
		go(1'b1, SIZE_MAIL, 1'b1, 2'h3, L);
		go(1'b0, SIZE_MAIL, 1'b1, 2'h1, L);
		chk(36'({o_b2a_wr_en, o_b2a_mail_wr}), 36'h1);
		chk(o_b2a_mail_data, L);
		fin();
		chk(o_portb_data, M);
		chk(36'(o_a2b_pop), 36'h0);
		ho = M;
		// word and byte pieces, reads then writes, swap changed mid-word
		for (int r = 0; r < 2; r++)
		for (int s = 1; s < 3; s++)
		for (int b = 0; b < 2; b++)
		for (int m = 0; m < 4; m++) begin
			n = (s == 2) ? 2 : 4;
			w = 36 / n;
			mk = b ? ~(ALL >> w) : ~(ALL << w);
			i_a2b_data <= A;
			for (int k = 0; k <= n; k++) begin
				if (k < n)
					go(r[0], 2'(s), b[0], 2'(k ? ~m : m),
						(sh(L, b, w * k) & mk) | (~L & ~mk));
				else
					fin();
				if (k > 0 && r == 1) begin
					chk(36'(o_b2a_wr_en), 36'(k == n));
					if (k == n)
						chk(o_b2a_wr_data, sw(L, 2'(m)));
				end
				if (k > 0 && r == 0) begin
					if (k < n) i_a2b_data <= ~A;
					ho = (ho & ~mk) | (sh(sw(A, 2'(m)), b, w * (k - 1)) & mk);
					chk(o_portb_data, ho);
					chk(36'(o_a2b_pop), 36'(k == 1));
				end
			end
		end
		// new size with a word pending drops it
		axw(ADDR_STATUS, 32'h0000_000f);
		go(1'b1, SIZE_WORD, 1'b1, 2'h0, L);
		go(1'b1, SIZE_LONG, 1'b1, 2'h0, A);
		chk(36'(o_b2a_wr_en), 36'h0);
		fin();
		chk(o_b2a_wr_data, A);
		axr(ADDR_STATUS, rd, rr);
		chk(36'(rd[EV_LOST]), 36'h1);
		// parity flag only on active word lanes
		axw(ADDR_STATUS, 32'h0000_000f);
		for (int b = 0; b < 2; b++) begin
			go(1'b1, SIZE_WORD, b[0], 2'h0, b ? 36'h1 : 36'h8_0000_0000);
			go(1'b1, SIZE_WORD, b[0], 2'h0, b ? 36'h8_0000_0000 : 36'h1);
			chk(36'(o_portb_parity_err_n), 36'h1);
			fin();
			chk(36'(o_portb_parity_err_n), 36'h0);
		end
		axr(ADDR_STATUS, rd, rr);
		chk(36'(rd), 36'((1 << EV_COMMIT) | (1 << EV_PARITY)));
		// interrupt raised, masked, cleared
		chk(36'(o_irq), 36'h0);
		axw(ADDR_MASK, 32'(1 << EV_PARITY));
		#1;
		chk(36'(o_irq), 36'h1);
		axw(ADDR_STATUS, 32'(1 << EV_PARITY));
		#1;
		chk(36'(o_irq), 36'h0);
		axr(ADDR_STATUS, rd, rr);
		chk(36'(rd), 36'(1 << EV_COMMIT));
		// odd parity flags an all-zero word, then the port is switched off
		axw(ADDR_CTRL, 32'h0000_0003);
		go(1'b1, SIZE_LONG, 1'b0, 2'h0, 36'h0_0000_0000);
		fin();
		chk(36'(o_portb_parity_err_n), 36'h0);
		axw(ADDR_CTRL, 32'h0000_0002);
		go(1'b1, SIZE_LONG, 1'b0, 2'h0, L);
		go(1'b0, SIZE_LONG, 1'b0, 2'h0, L);
		chk(36'({o_b2a_wr_en, o_portb_data_oe, o_portb_parity_err_n}),
			36'h1);
		fin();
		chk(36'(o_a2b_pop), 36'h0);
		print_verdict();
	end
endmodule
